// [logic/lsar_top.sv]
// link status and alias register bank, avalon-mm slave
//
// What this block does
// - target address bits 7:1 replace the address of alias-matched i2c requests.
// - alias bits 7:1 select which local i2c requests are remapped.
// - zero in target or alias blocks every forward for that target.
// - sixteen-bit back-channel crc error count, low byte 0x0a, high 0x0b.
// - crc error reset bit 0x04[5] clears the counter to zero.
// - status bit 4 sets on link loss, holds until crc error reset.
// - status bit 3 sets on selftest crc errors; cleared by loss, restart, reset.
// - status bit 2 shows live input clock presence.
// - status bit 1 sets on normal crc errors; cleared by loss or reset.
// - status bit 0 shows live link detect of the selected port.
// - secondary port select routes per-port registers to the second port.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module lsar_top
   import lsar_pkg::*;
#(
   parameter int unsigned NPORT = NPORT_DEF
) (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // avalon-mm slave
   input  wire logic [7:0]            avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [3:0]            avs_byteenable_i,
   input  wire logic [31:0]           avs_writedata_i,
   output logic      [31:0]           avs_readdata_o,
   output logic                       avs_waitrequest_o,
   // link status per port
   input  wire logic [NPORT-1:0]      link_detect_i,
   input  wire logic [NPORT-1:0]      bc_crc_err_i,
   input  wire logic [NPORT-1:0]      selftest_active_i,
   input  wire logic [NPORT-1:0]      selftest_start_i,
   input  wire logic                  input_clock_present_i,
   // local i2c address phase and forwarded copies
   input  wire lsar_i2c_t             i2c_req_i,
   output lsar_i2c_t [NPORT-1:0]      i2c_fwd_o,
   output logic      [NPORT-1:0]      i2c_blocked_o,
   // interrupt
   output logic                       irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // elaboration check: select is a single bit
   if (NPORT < 1 || NPORT > 2) begin : g_bad_nport
      $error("NPORT must be 1 or 2");
   end

   // bus handshake states, gray along idle -> answer
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_ANS  = 2'b01
   } lsar_bus_t;

   // true when the byte address hits a word index
   function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
      return a[7:2] == idx && a[1:0] == 2'b00;
   endfunction

   // assemble the status byte of one port
   function automatic logic [7:0] stat_byte(input lsar_pstat_t s, input logic clk_ok);
      logic [7:0] b;
      b           = 8'h00;
      b[ST_LOST]  = s.lost;
      b[ST_SELF]  = s.self_err;
      b[ST_CLK]   = clk_ok;
      b[ST_DES]   = s.des_err;
      b[ST_LINK]  = s.link;
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   lsar_bus_t                  state_r, state_nxt;
   logic                       wait_r, wait_nxt;
   logic [31:0]                rdata_r, rdata_nxt;
   logic [NPORT-1:0][6:0]      tgt_r, tgt_nxt;
   logic [NPORT-1:0][6:0]      alias_r, alias_nxt;
   logic                       crc_clr_r, crc_clr_nxt;
   logic                       psel_r, psel_nxt;
   logic [IRQ_W-1:0]           irq_st_r, irq_st_nxt;
   logic [IRQ_W-1:0]           irq_msk_r, irq_msk_nxt;
   logic                       irq_r, irq_nxt;
   logic [NPORT-1:0][15:0]     cnt;
   lsar_pstat_t [NPORT-1:0]    pstat;
   logic [NPORT-1:0]           ev_lost, ev_des, ev_self;
   logic [IRQ_W-1:0]           ev_vec;
   logic                       wr_take;
   logic                       sel;

   // the selected port; a single-port build ignores the select
   assign sel     = (NPORT > 1) ? psel_r : 1'b0;
   assign wr_take = state_r == S_ANS && avs_write_i && avs_byteenable_i[0];

   ////////////////////////////////////////////////////////////////////////////
   // per-port status and remap
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      lsar_port u_port (
         .clk_i       (clk_i),
         .rst_i       (rst_i),
         .link_i      (link_detect_i[p]),
         .bc_err_i    (bc_crc_err_i[p]),
         .st_active_i (selftest_active_i[p]),
         .st_start_i  (selftest_start_i[p]),
         .crc_clr_i   (crc_clr_r),
         .cnt_o       (cnt[p]),
         .stat_o      (pstat[p]),
         .ev_lost_o   (ev_lost[p]),
         .ev_des_o    (ev_des[p]),
         .ev_self_o   (ev_self[p])
      );
      lsar_remap u_remap (
         .clk_i       (clk_i),
         .rst_i       (rst_i),
         .req_i       (i2c_req_i),
         .tgt_i       (tgt_r[p]),
         .alias_i     (alias_r[p]),
         .fwd_o       (i2c_fwd_o[p]),
         .blocked_o   (i2c_blocked_o[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait cycle, then a single answer cycle
   always_comb begin
      state_nxt = state_r;
      wait_nxt  = 1'b1;
      rdata_nxt = rdata_r;
      case (state_r)
         S_IDLE: begin
            if (avs_read_i || avs_write_i) begin
               state_nxt = S_ANS;
               wait_nxt  = 1'b0;
               rdata_nxt = 32'h0000_0000;
               if (avs_read_i) begin
                  // unmapped words read as zero
                  case (avs_address_i[7:2])
                     IDX_CTRL:    rdata_nxt[CTRL_CRC_RST] = crc_clr_r;
                     IDX_TGT:     rdata_nxt[7:1] = tgt_r[sel];
                     IDX_ALIAS:   rdata_nxt[7:1] = alias_r[sel];
                     IDX_CNT_LO:  rdata_nxt[7:0] = cnt[sel][7:0];
                     IDX_CNT_HI:  rdata_nxt[7:0] = cnt[sel][15:8];
                     IDX_STAT: begin
                        rdata_nxt[7:0] = stat_byte(pstat[sel], input_clock_present_i);
                     end
                     IDX_PSEL:    rdata_nxt[0] = psel_r;
                     IDX_IRQ_ST:  rdata_nxt[IRQ_W-1:0] = irq_st_r;
                     IDX_IRQ_MSK: rdata_nxt[IRQ_W-1:0] = irq_msk_r;
                     default:     rdata_nxt = 32'h0000_0000;
                  endcase
                  if (avs_address_i[1:0] != 2'b00) begin
                     rdata_nxt = 32'h0000_0000;
                  end
               end
            end
         end
         S_ANS: begin
            state_nxt = S_IDLE;
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= S_IDLE;
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         wait_r  <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_waitrequest_o = wait_r;
   assign avs_readdata_o    = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers; writes land at the accepting edge
   always_comb begin
      tgt_nxt     = tgt_r;
      alias_nxt   = alias_r;
      crc_clr_nxt = crc_clr_r;
      psel_nxt    = psel_r;
      irq_msk_nxt = irq_msk_r;
      if (wr_take) begin
         if (hit(avs_address_i, IDX_TGT)) begin
            tgt_nxt[sel] = avs_writedata_i[7:1];
         end
         if (hit(avs_address_i, IDX_ALIAS)) begin
            alias_nxt[sel] = avs_writedata_i[7:1];
         end
         if (hit(avs_address_i, IDX_CTRL)) begin
            crc_clr_nxt = avs_writedata_i[CTRL_CRC_RST];
         end
         if (hit(avs_address_i, IDX_PSEL)) begin
            psel_nxt = (NPORT > 1) ? avs_writedata_i[0] : 1'b0;
         end
         if (hit(avs_address_i, IDX_IRQ_MSK)) begin
            irq_msk_nxt = avs_writedata_i[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tgt_r     <= '0;
         alias_r   <= '0;
         crc_clr_r <= 1'b0;
         psel_r    <= 1'b0;
         irq_msk_r <= '0;
      end else begin
         tgt_r     <= tgt_nxt;
         alias_r   <= alias_nxt;
         crc_clr_r <= crc_clr_nxt;
         psel_r    <= psel_nxt;
         irq_msk_r <= irq_msk_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky interrupt status, write one to clear; a same-cycle event wins
   always_comb begin
      ev_vec           = '0;
      ev_vec[IRQ_LOST] = |ev_lost;
      ev_vec[IRQ_DES]  = |ev_des;
      ev_vec[IRQ_SELF] = |ev_self;
      irq_st_nxt       = irq_st_r;
      if (wr_take && hit(avs_address_i, IDX_IRQ_ST)) begin
         irq_st_nxt = irq_st_r & ~avs_writedata_i[IRQ_W-1:0];
      end
      irq_st_nxt = irq_st_nxt | ev_vec;
      // registered so the pin never glitches on decode
      irq_nxt    = |(irq_st_r & irq_msk_r);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st_r <= '0;
         irq_r    <= 1'b0;
      end else begin
         irq_st_r <= irq_st_nxt;
         irq_r    <= irq_nxt;
      end
   end

   assign irq_o = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_req;
      state_r == S_IDLE && (avs_read_i || avs_write_i);
   endsequence
   sequence s_rd(logic [5:0] idx);
      state_r == S_IDLE && avs_read_i && avs_address_i == {idx, 2'b00};
   endsequence

   a_bus_answer: assert property (s_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("answer cycle missing");
   a_tgt_store: assert property (wr_take && avs_address_i == {IDX_TGT, 2'b00}
      |=> tgt_r[$past(sel)] == $past(avs_writedata_i[7:1]))
      else $error("target write lost");
   a_alias_store: assert property (wr_take && avs_address_i == {IDX_ALIAS, 2'b00}
      |=> alias_r[$past(sel)] == $past(avs_writedata_i[7:1]))
      else $error("alias write lost");
   a_psel_read: assert property (s_rd(IDX_TGT) |=> avs_readdata_o[7:1] == tgt_r[sel])
      else $error("wrong port copy read");
   a_stat_live: assert property (s_rd(IDX_STAT)
      |=> avs_readdata_o[ST_CLK] == $past(input_clock_present_i)
      && avs_readdata_o[ST_LINK] == $past(link_detect_i[sel]))
      else $error("status bits not live");
   a_cnt_read: assert property (s_rd(IDX_CNT_HI) |=> avs_readdata_o[7:0]
      == $past(cnt[sel][15:8]) && avs_readdata_o[31:8] == 24'h000000)
      else $error("counter high byte wrong");
   a_lost_irq: assert property (|ev_lost |=> irq_st_r[IRQ_LOST])
      else $error("lost event dropped");
   a_irq_level: assert property (|(irq_st_r & irq_msk_r) |=> irq_o)
      else $error("interrupt not raised");
endmodule
`default_nettype wire

// [logic/lsar_pkg.sv]
// package: register map, field positions, reset values and carriers
`default_nettype none
package lsar_pkg;
   // word indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL    = 6'h04;
   localparam logic [5:0] IDX_TGT     = 6'h07;
   localparam logic [5:0] IDX_ALIAS   = 6'h08;
   localparam logic [5:0] IDX_CNT_LO  = 6'h0a;
   localparam logic [5:0] IDX_CNT_HI  = 6'h0b;
   localparam logic [5:0] IDX_STAT    = 6'h0c;
   localparam logic [5:0] IDX_PSEL    = 6'h10;
   localparam logic [5:0] IDX_IRQ_ST  = 6'h11;
   localparam logic [5:0] IDX_IRQ_MSK = 6'h12;
   // field positions
   localparam int unsigned CTRL_CRC_RST = 5;
   localparam int unsigned ST_LOST      = 4;
   localparam int unsigned ST_SELF      = 3;
   localparam int unsigned ST_CLK       = 2;
   localparam int unsigned ST_DES       = 1;
   localparam int unsigned ST_LINK      = 0;
   localparam int unsigned IRQ_LOST     = 0;
   localparam int unsigned IRQ_DES      = 1;
   localparam int unsigned IRQ_SELF     = 2;
   localparam int unsigned IRQ_W        = 3;
   // reset values
   localparam logic [6:0]  RST_ADDR  = 7'h00;
   localparam logic [15:0] RST_CNT   = 16'h0000;
   localparam logic [15:0] CNT_MAX   = 16'hffff;
   localparam int unsigned NPORT_DEF = 2;
   // live and sticky state of one port
   typedef struct packed {
      logic lost;
      logic self_err;
      logic des_err;
      logic link;
   } lsar_pstat_t;
   // one i2c address phase
   typedef struct packed {
      logic       valid;
      logic [6:0] addr;
   } lsar_i2c_t;
endpackage
`default_nettype wire

// [logic/lsar_port.sv]
// one port: crc error counter and sticky link flags
`timescale 1ns/10ps
`default_nettype none
module lsar_port
   import lsar_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // link side
   input  wire logic        link_i,
   input  wire logic        bc_err_i,
   input  wire logic        st_active_i,
   input  wire logic        st_start_i,
   input  wire logic        crc_clr_i,
   // results
   output logic [15:0]      cnt_o,
   output lsar_pstat_t      stat_o,
   output logic             ev_lost_o,
   output logic             ev_des_o,
   output logic             ev_self_o
);
   logic        link_d_r, link_d_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic        lost_r, lost_nxt, self_r, self_nxt, des_r, des_nxt;
   logic        loss;

   ////////////////////////////////////////////////////////////////////////////
   // next state; a new event beats a clear in the same cycle
   always_comb begin
      loss       = link_d_r & ~link_i;
      link_d_nxt = link_i;
      if (crc_clr_i) begin
         cnt_nxt = bc_err_i ? 16'h0001 : RST_CNT;
      end else if (bc_err_i && cnt_r != CNT_MAX) begin
         cnt_nxt = cnt_r + 16'h0001;
      end else begin
         cnt_nxt = cnt_r;
      end
      lost_nxt = loss | (lost_r & ~crc_clr_i);
      self_nxt = (bc_err_i & st_active_i)
               | (self_r & ~(crc_clr_i | loss | st_start_i));
      des_nxt  = (bc_err_i & ~st_active_i)
               | (des_r & ~(crc_clr_i | loss));
   end

   // registers only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link_d_r <= 1'b0;
         cnt_r    <= RST_CNT;
         lost_r   <= 1'b0;
         self_r   <= 1'b0;
         des_r    <= 1'b0;
      end else begin
         link_d_r <= link_d_nxt;
         cnt_r    <= cnt_nxt;
         lost_r   <= lost_nxt;
         self_r   <= self_nxt;
         des_r    <= des_nxt;
      end
   end

   assign cnt_o     = cnt_r;
   assign stat_o    = '{lost: lost_r, self_err: self_r, des_err: des_r, link: link_i};
   assign ev_lost_o = loss;
   assign ev_des_o  = bc_err_i & ~st_active_i;
   assign ev_self_o = bc_err_i & st_active_i;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_loss;
      link_d_r && !link_i;
   endsequence
   a_cnt_clear: assert property (crc_clr_i && !bc_err_i |=> cnt_r == 16'h0000)
      else $error("counter not cleared");
   a_cnt_incr: assert property (bc_err_i && !crc_clr_i && cnt_r != CNT_MAX
      |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("counter missed an error");
   a_cnt_sat: assert property (cnt_r == CNT_MAX && !crc_clr_i |=> cnt_r == CNT_MAX)
      else $error("counter wrapped");
   a_lost_sticky: assert property (s_loss ##1 !crc_clr_i[*2] |-> lost_r)
      else $error("link lost flag dropped");
   a_self_clear: assert property (s_loss and !bc_err_i |=> !self_r)
      else $error("selftest flag kept on loss");
   a_des_set: assert property (bc_err_i && !st_active_i |=> des_r ##1 (des_r || $past(crc_clr_i)
      || $past(loss)))
      else $error("error flag not set");
endmodule
`default_nettype wire

// [logic/lsar_remap.sv]
// alias match and target address substitution for one port
`timescale 1ns/10ps
`default_nettype none
module lsar_remap
   import lsar_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // request and mapping
   input  wire lsar_i2c_t  req_i,
   input  wire logic [6:0] tgt_i,
   input  wire logic [6:0] alias_i,
   // forwarded request
   output lsar_i2c_t       fwd_o,
   output logic            blocked_o
);
   lsar_i2c_t fwd_r, fwd_nxt;
   logic      blk_r, blk_nxt, hit;

   ////////////////////////////////////////////////////////////////////////////
   // a zero alias never matches, so general calls are never forwarded
   always_comb begin
      hit           = req_i.valid && alias_i != RST_ADDR && req_i.addr == alias_i;
      fwd_nxt.valid = hit && tgt_i != RST_ADDR;
      fwd_nxt.addr  = fwd_nxt.valid ? tgt_i : RST_ADDR;
      blk_nxt       = hit && tgt_i == RST_ADDR;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fwd_r <= '0;
         blk_r <= 1'b0;
      end else begin
         fwd_r <= fwd_nxt;
         blk_r <= blk_nxt;
      end
   end

   assign fwd_o     = fwd_r;
   assign blocked_o = blk_r;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_fwd_swap: assert property (req_i.valid && req_i.addr == alias_i && alias_i != 7'h00
      && tgt_i != 7'h00 |=> fwd_r.valid && fwd_r.addr == $past(tgt_i))
      else $error("alias not remapped");
   a_zero_block: assert property (tgt_i == 7'h00 || alias_i == 7'h00 |=> !fwd_r.valid)
      else $error("forwarded with zero field");
endmodule
`default_nettype wire

// [verification/lsar_des_model.sv]
// remote deserializer model: link health towards the bank, takes forwarded i2c
`timescale 1ns/10ps
`default_nettype none
module lsar_des_model
   import lsar_pkg::*;
(
   // clock
   input  wire logic            clk_i,
   // link health seen by the bank
   output logic      [1:0]      link_o,
   output logic      [1:0]      err_o,
   output logic      [1:0]      st_act_o,
   output logic      [1:0]      st_go_o,
   // forwarded requests and last one taken
   input  wire lsar_i2c_t [1:0] fwd_i,
   output lsar_i2c_t [1:0]      last_o
);
   // cable present from power up, so release of reset is no loss
   initial begin
      link_o = 2'h3;
      err_o = 2'h0;
      st_act_o = 2'h0;
      st_go_o = 2'h0;
      last_o = '0;
   end
   // errors back to back, as the back channel may send them
   task errs(input int p, input int n, input logic st);
      @(posedge clk_i);
      st_act_o[p] <= st;
      st_go_o[p] <= st;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         st_go_o[p] <= 1'b0;
         err_o[p] <= 1'b1;
      end
      @(posedge clk_i);
      st_go_o[p] <= 1'b0;
      err_o[p] <= 1'b0;
      st_act_o[p] <= 1'b0;
   endtask
   // cable plug or unplug
   task link(input int p, input logic v);
      @(posedge clk_i);
      link_o[p] <= v;
   endtask
   // keep the last address that crossed the channel per port
   always @(posedge clk_i) begin
      for (int p = 0; p < 2; p++) begin
         if (fwd_i[p].valid === 1'b1) last_o[p] <= fwd_i[p];
      end
   end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the link status and alias register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import lsar_pkg::*;
   logic             clk_i;
   logic             rst_i;
   logic [7:0]       adr;
   logic             rd;
   logic             wr;
   logic [31:0]      wd;
   logic [31:0]      rdat;
   logic             wq;
   logic [3:0]       be;
   logic             icp;
   logic             irq;
   logic [1:0]       lnk, err, sta, stg, blk;
   lsar_i2c_t        req_r;
   lsar_i2c_t [1:0]  fwd, last;
   logic [7:0]       q;
   int               compares, miscompares;
   ////////////////////////////////////////////////////////////////
   lsar_top u_lsar_top (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
      .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
      .link_detect_i(lnk), .bc_crc_err_i(err), .selftest_active_i(sta),
      .selftest_start_i(stg), .input_clock_present_i(icp), .i2c_req_i(req_r),
      .i2c_fwd_o(fwd), .i2c_blocked_o(blk), .irq_o(irq));
   lsar_des_model u_lsar_des_model (.clk_i(clk_i), .link_o(lnk), .err_o(err),
      .st_act_o(sta), .st_go_o(stg), .fwd_i(fwd), .last_o(last));
   ////////////////////////////////////////////////////////////////
   // clock, 20 ns period
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic final_report;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one avalon access; held until waitrequest is sampled low
   // no cycle count assumed here; only the watchdog ends a hung wait
   task automatic acc(input logic w, input logic [5:0] i, input logic [7:0] d);
      @(posedge clk_i);
      adr <= {i, 2'h0};
      rd <= !w;
      wr <= w;
      wd <= {24'h0, d};
      do begin
         @(posedge clk_i);
      end while (wq !== 1'b0);
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [5:0] i, input logic [7:0] e);
      acc(1'b0, i, 8'h00);
      chk(q, e);
   endtask
   // one address phase, then look at the forwarded copies
   task automatic req(input logic [6:0] a);
      @(posedge clk_i);
      req_r <= {1'b1, a};
      @(posedge clk_i);
      req_r <= '0;
      @(negedge clk_i);
   endtask
   // watchdog: the saturation burst plus accesses stays well under this
   initial begin
      repeat (80000) @(posedge clk_i);
      miscompares++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      compares = 0;
      miscompares = 0;
      rst_i = 1'b1;
      adr = 8'h00;
      rd = 1'b0;
      wr = 1'b0;
      be = 4'h1;
      wd = 32'h0;
      icp = 1'b0;
      req_r = '0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, unmapped place, live link
      rchk(IDX_TGT, 8'h00);
      rchk(IDX_ALIAS, 8'h00);
      rchk(IDX_CNT_LO, 8'h00);
      rchk(IDX_CNT_HI, 8'h00);
      rchk(IDX_STAT, 8'h01);
      rchk(6'h3f, 8'h00);
      // port 0 mapping; bit 0 is reserved and reads 0
      acc(1'b1, IDX_TGT, 8'h5b);
      rchk(IDX_TGT, 8'h5a);
      acc(1'b1, IDX_ALIAS, 8'h22);
      rchk(IDX_ALIAS, 8'h22);
      req(7'h11);
      chk(fwd[0], 8'had);
      chk(fwd[1], 8'h00);
      req(7'h12);
      chk(fwd[0], 8'h00);
      chk(last[0], 8'had);
      // port 1 copies, target still zero so blocked
      acc(1'b1, IDX_PSEL, 8'h01);
      rchk(IDX_TGT, 8'h00);
      acc(1'b1, IDX_ALIAS, 8'h22);
      req(7'h11);
      chk({6'h0, blk}, 8'h02);
      chk(fwd[1], 8'h00);
      chk(fwd[0], 8'had);
      acc(1'b1, IDX_TGT, 8'h30);
      req(7'h11);
      chk(fwd[1], 8'h98);
      acc(1'b1, IDX_PSEL, 8'h00);
      rchk(IDX_TGT, 8'h5a);
      // a write with lane 0 disabled must be ignored
      @(posedge clk_i);
      be <= 4'h0;
      acc(1'b1, IDX_TGT, 8'h7e);
      @(posedge clk_i);
      be <= 4'h1;
      rchk(IDX_TGT, 8'h5a);
      acc(1'b1, IDX_ALIAS, 8'h00);
      req(7'h00);
      chk(fwd[0], 8'h00);
      // normal crc errors, counted and flagged, irq masked in
      acc(1'b1, IDX_IRQ_MSK, 8'h02);
      u_lsar_des_model.errs(0, 3, 1'b0);
      rchk(IDX_CNT_LO, 8'h03);
      rchk(IDX_CNT_HI, 8'h00);
      rchk(IDX_STAT, 8'h03);
      rchk(IDX_IRQ_ST, 8'h02);
      chk({7'h0, irq}, 8'h01);
      acc(1'b1, IDX_IRQ_ST, 8'h02);
      rchk(IDX_IRQ_ST, 8'h00);
      chk({7'h0, irq}, 8'h00);
      // self-test error, then restart clears its flag; masked irq stays low
      u_lsar_des_model.errs(0, 1, 1'b1);
      rchk(IDX_STAT, 8'h0b);
      rchk(IDX_CNT_LO, 8'h04);
      chk({7'h0, irq}, 8'h00);
      u_lsar_des_model.errs(0, 0, 1'b1);
      rchk(IDX_STAT, 8'h03);
      // live input clock
      @(posedge clk_i);
      icp <= 1'b1;
      rchk(IDX_STAT, 8'h07);
      @(posedge clk_i);
      icp <= 1'b0;
      rchk(IDX_STAT, 8'h03);
      // link loss: sticky lost, error flags cleared, counter kept
      u_lsar_des_model.errs(0, 1, 1'b1);
      u_lsar_des_model.link(0, 1'b0);
      rchk(IDX_STAT, 8'h10);
      rchk(IDX_IRQ_ST, 8'h05);
      u_lsar_des_model.link(0, 1'b1);
      rchk(IDX_STAT, 8'h11);
      rchk(IDX_CNT_LO, 8'h05);
      acc(1'b1, IDX_CTRL, 8'h20);
      acc(1'b1, IDX_CTRL, 8'h00);
      rchk(IDX_STAT, 8'h01);
      rchk(IDX_CNT_LO, 8'h00);
      // port 1 burst past the top of the counter
      u_lsar_des_model.errs(1, 65537, 1'b0);
      acc(1'b1, IDX_PSEL, 8'h01);
      rchk(IDX_CNT_LO, 8'hff);
      rchk(IDX_CNT_HI, 8'hff);
      acc(1'b1, IDX_PSEL, 8'h00);
      rchk(IDX_CNT_LO, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
